// >>> core/cbfc_exec.sv
// module: decode and execute of the branch, call and clear instruction group
//
// How it works
// - call saves next-after-slot, adds operand register
// - delayed branch redirects only after slot completes
// - target captured before slot can change register
// - flag-set branch tests flag, else sequential
// - displacement sign-extended and doubled
// - branch target is own address plus four plus displacement
// - flag-set branch takes three or one cycles
// - flag-set branch in slot is illegal
// - delayed flag branch executes slot, two cycles
// - taken delayed branch blocks interrupts until slot
// - branch in taken delayed slot is illegal
// - untaken delayed branch acts as no-op
// - accumulator clear zeroes both halves, one cycle
// - clamp clear zeroes saturation bit, one cycle
// - compare clear zeroes condition flag, one cycle
// - call blocks interrupts, branch in slot illegal
//
// Chosen here: the address-and-strobe port and the register addresses.
module cbfc_exec (
  input  wire logic        core_clk,        // core clock, 20 MHz
  input  wire logic        sys_rst,         // synchronous reset, high
  // instruction issue
  input  wire logic        instr_valid,     // instruction presented at pc
  input  wire logic [15:0] instr,           // instruction word
  input  wire logic [31:0] operand_reg,     // value of the named register
  input  wire logic        ext_branch,      // word is a branch decoded elsewhere
  input  wire logic        ext_redirect,    // pc load from outside
  input  wire logic [31:0] ext_target,      // address for ext_redirect
  input  wire logic        flag_wr,         // flag update from other logic
  input  wire logic        flag_wr_val,     // value for flag_wr
  input  wire logic        sat_wr,          // saturation update from outside
  input  wire logic        sat_wr_val,      // value for sat_wr
  output logic             instr_ready_q,   // instruction is taken this cycle
  output logic [31:0]      pc_q,            // address of next instruction
  output logic [31:0]      return_addr_q,   // subroutine return address
  output logic [31:0]      accum_high_q,    // accumulator high half
  output logic [31:0]      accum_low_q,     // accumulator low half
  output logic             flag_q,          // condition flag
  output logic             sat_q,           // saturation bit
  output logic             int_block_q,     // interrupts must not be taken
  output logic             illegal_slot_q,  // one-cycle illegal slot pulse
  // register port
  input  wire logic [4:0]  reg_addr,        // byte address
  input  wire logic [31:0] reg_wdata,       // write data
  input  wire logic        reg_wr,          // write strobe
  input  wire logic        reg_rd,          // read strobe
  output logic [31:0]      reg_rdata_q,     // read data, one cycle later
  output logic             irq_q            // level interrupt
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cbfc_pkg::cbfc_state_t state_q;          // sequencing state
  cbfc_pkg::cbfc_state_t state_d;          // next sequencing state
  logic [31:0]           target_q;         // captured delayed target
  logic [cbfc_pkg::EV_COUNT-1:0] status_q; // sticky event bits
  logic [cbfc_pkg::EV_COUNT-1:0] mask_q;   // interrupt enables

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire dec_bt     = instr[15:8] == cbfc_pkg::OP_BRANCH_ON_FLAG_SET;
  wire dec_bts    = instr[15:8] == cbfc_pkg::OP_DELAYED_BRANCH_SET;
  wire dec_call   = (instr[15:12] == cbfc_pkg::OP_CALL_HI_NIBBLE) &&
                    (instr[7:0] == cbfc_pkg::OP_CALL_LO_BYTE);
  wire dec_accz   = instr == cbfc_pkg::OP_ACCUMULATOR_ZERO;
  wire dec_clampz = instr == cbfc_pkg::OP_CLAMP_BIT_ZERO;
  wire dec_cmpz   = instr == cbfc_pkg::OP_COMPARE_BIT_ZERO;
  wire is_branch  = dec_bt | dec_bts | dec_call | ext_branch;

  // ----------------------------------------------------------------
  // issue qualification
  // ----------------------------------------------------------------
  wire issue      = instr_valid & instr_ready_q;
  wire in_run     = state_q == cbfc_pkg::CBFC_RUN;
  wire in_slot    = state_q == cbfc_pkg::CBFC_SLOT;
  wire run_exec   = issue & in_run & ~ext_redirect;
  wire slot_exec  = issue & in_slot & ~is_branch & ~ext_redirect;
  // illegal slot: any branch in a delay slot
  // slot branch check
  wire slot_bad   = issue & in_slot & is_branch & ~ext_redirect;
  wire exec_ok    = run_exec | slot_exec;

  // ----------------------------------------------------------------
  // branch decisions
  // ----------------------------------------------------------------
  // flag test
  wire bt_go      = run_exec & dec_bt & flag_q;
  wire bts_go     = run_exec & dec_bts & flag_q;
  wire call_go    = run_exec & dec_call;
  wire dly_go     = bts_go | call_go;

  // ----------------------------------------------------------------
  // address arithmetic
  // ----------------------------------------------------------------
  // sign extend and double
  wire [31:0] disp_ext  = {{23{instr[7]}}, instr[7:0], 1'b0};
  // base is own address plus four
  wire [31:0] pc_base   = pc_q + cbfc_pkg::PC_BASE_OFFSET;
  wire [31:0] pc_seq    = pc_q + cbfc_pkg::PC_STEP;
  wire [31:0] disp_tgt  = pc_base + disp_ext;
  wire [31:0] call_tgt  = pc_base + operand_reg;

  // ----------------------------------------------------------------
  // next program counter
  // ----------------------------------------------------------------
  // delayed target taken only when the slot completes
  wire [31:0] pc_d = ext_redirect ? ext_target :
                     slot_exec    ? target_q   :
                     bt_go        ? disp_tgt   :
                     run_exec     ? pc_seq     :
                                    pc_q;

  wire [31:0] target_d = call_go ? call_tgt :
                         bts_go  ? disp_tgt :
                                   target_q;

  // return address is after the slot
  wire [31:0] return_addr_d = call_go ? pc_base : return_addr_q;

  // ----------------------------------------------------------------
  // architectural bits
  // ----------------------------------------------------------------
  // flag clear wins over other writes
  wire flag_d = (exec_ok & dec_cmpz) ? 1'b0 :
                flag_wr              ? flag_wr_val :
                                       flag_q;
  wire sat_d  = (exec_ok & dec_clampz) ? 1'b0 :
                sat_wr                 ? sat_wr_val :
                                         sat_q;
  wire acc_clr = exec_ok & dec_accz;

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  // next state decision
  always_comb begin
    state_d = state_q;
    if (ext_redirect) begin
      state_d = cbfc_pkg::CBFC_RUN;
    end else begin
      case (state_q)
        cbfc_pkg::CBFC_RUN: begin
          if (bt_go) begin
            state_d = cbfc_pkg::CBFC_BR_WAIT2;
          end else if (dly_go) begin
            state_d = cbfc_pkg::CBFC_DL_WAIT;
          end
        end
        cbfc_pkg::CBFC_BR_WAIT2: begin
          state_d = cbfc_pkg::CBFC_BR_WAIT1;
        end
        cbfc_pkg::CBFC_BR_WAIT1: begin
          state_d = cbfc_pkg::CBFC_RUN;
        end
        cbfc_pkg::CBFC_DL_WAIT: begin
          state_d = cbfc_pkg::CBFC_SLOT;
        end
        cbfc_pkg::CBFC_SLOT: begin
          // slot completes or is refused
          if (issue) begin
            state_d = cbfc_pkg::CBFC_RUN;
          end
        end
        default: begin
          state_d = cbfc_pkg::CBFC_RUN;
        end
      endcase
    end
  end

  wire ready_d = (state_d == cbfc_pkg::CBFC_RUN) ||
                 (state_d == cbfc_pkg::CBFC_SLOT);
  wire int_block_d = (state_d == cbfc_pkg::CBFC_DL_WAIT) ||
                     (state_d == cbfc_pkg::CBFC_SLOT);

  // state and handshake registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_q       <= cbfc_pkg::CBFC_RUN;
      instr_ready_q <= 1'b1;
      int_block_q   <= 1'b0;
    end else begin
      state_q       <= state_d;
      instr_ready_q <= ready_d;
      int_block_q   <= int_block_d;
    end
  end

  // program counter and addresses
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pc_q          <= cbfc_pkg::PC_RESET;
      target_q      <= cbfc_pkg::PC_RESET;
      return_addr_q <= cbfc_pkg::PC_RESET;
    end else begin
      pc_q          <= pc_d;
      target_q      <= target_d;
      return_addr_q <= return_addr_d;
    end
  end

  // flag, saturation bit, accumulator, illegal slot pulse
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      flag_q         <= 1'b0;
      sat_q          <= 1'b0;
      accum_high_q   <= 32'h0000_0000;
      accum_low_q    <= 32'h0000_0000;
      illegal_slot_q <= 1'b0;
    end else begin
      flag_q         <= flag_d;
      sat_q          <= sat_d;
      illegal_slot_q <= slot_bad;
      if (acc_clr) begin
        accum_high_q <= 32'h0000_0000;
        accum_low_q  <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // register port and interrupt
  // ----------------------------------------------------------------
  wire [cbfc_pkg::EV_COUNT-1:0] ev_set;  // events this cycle
  assign ev_set[cbfc_pkg::EV_ILLEGAL_SLOT] = slot_bad;
  assign ev_set[cbfc_pkg::EV_BRANCH_TAKEN] = bt_go | bts_go;
  assign ev_set[cbfc_pkg::EV_CALL]         = call_go;

  wire rd_status = reg_rd && (reg_addr == cbfc_pkg::REG_STATUS);
  wire wr_mask   = reg_wr && (reg_addr == cbfc_pkg::REG_MASK);
  // set wins over the read clear
  wire [cbfc_pkg::EV_COUNT-1:0] status_d =
    (rd_status ? '0 : status_q) | ev_set;
  wire [cbfc_pkg::EV_COUNT-1:0] mask_d =
    wr_mask ? reg_wdata[cbfc_pkg::EV_COUNT-1:0] : mask_q;

  // read multiplexer, unmapped reads give zero
  wire [31:0] state_word = {27'h0000000, int_block_q, in_slot,
                            sat_q, flag_q, instr_ready_q};
  wire [31:0] rd_mux =
    (reg_addr == cbfc_pkg::REG_STATUS)      ? {29'h0, status_q} :
    (reg_addr == cbfc_pkg::REG_MASK)        ? {29'h0, mask_q}   :
    (reg_addr == cbfc_pkg::REG_STATE)       ? state_word        :
    (reg_addr == cbfc_pkg::REG_PC)          ? pc_q              :
    (reg_addr == cbfc_pkg::REG_RETURN_ADDR) ? return_addr_q     :
                                              32'h0000_0000;

  // status, mask, read data, interrupt
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      status_q    <= '0;
      mask_q      <= cbfc_pkg::MASK_RESET;
      reg_rdata_q <= 32'h0000_0000;
      irq_q       <= 1'b0;
    end else begin
      status_q    <= status_d;
      mask_q      <= mask_d;
      reg_rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
      irq_q       <= |(status_d & mask_d);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // return address and call target
  property p_call_addr;
    @(posedge core_clk) disable iff (sys_rst)
      call_go |=> (return_addr_q == $past(pc_q) + 32'h0000_0004) &&
                  (target_q == $past(pc_q) + 32'h0000_0004 +
                               $past(operand_reg));
  endproperty
  a_call_addr: assert property (p_call_addr) else $error("call addr");

  property p_slot_redirect;
    @(posedge core_clk) disable iff (sys_rst)
      slot_exec |=> pc_q == $past(target_q);
  endproperty
  a_slot_redirect: assert property (p_slot_redirect)
    else $error("slot redirect");

  property p_target_hold;
    @(posedge core_clk) disable iff (sys_rst)
      (in_slot && !issue) |=> $stable(target_q);
  endproperty
  a_target_hold: assert property (p_target_hold)
    else $error("target moved");

  property p_bt_fall;
    @(posedge core_clk) disable iff (sys_rst)
      (run_exec && dec_bt && !flag_q) |=>
        (pc_q == $past(pc_q) + 32'h0000_0002) && instr_ready_q;
  endproperty
  a_bt_fall: assert property (p_bt_fall) else $error("bt fall");

  property p_bt_target;
    @(posedge core_clk) disable iff (sys_rst)
      bt_go |=> pc_q == $past(pc_q) + 32'h0000_0004 +
                {{23{$past(instr[7])}}, $past(instr[7:0]), 1'b0};
  endproperty
  a_bt_target: assert property (p_bt_target) else $error("bt target");

  property p_bt_cycles;
    @(posedge core_clk) disable iff (sys_rst || ext_redirect)
      bt_go |=> !instr_ready_q ##1 !instr_ready_q ##1 instr_ready_q;
  endproperty
  a_bt_cycles: assert property (p_bt_cycles) else $error("bt cycles");

  property p_slot_illegal;
    @(posedge core_clk) disable iff (sys_rst)
      (issue && in_slot && is_branch && !ext_redirect) |=>
        illegal_slot_q && $stable(pc_q) && in_run;
  endproperty
  a_slot_illegal: assert property (p_slot_illegal)
    else $error("illegal slot missed");

  property p_bts_seq;
    @(posedge core_clk) disable iff (sys_rst || ext_redirect)
      bts_go |=> (!instr_ready_q && int_block_q)
                 ##1 (instr_ready_q && int_block_q && in_slot);
  endproperty
  a_bts_seq: assert property (p_bts_seq) else $error("bts seq");

  property p_bts_nop;
    @(posedge core_clk) disable iff (sys_rst)
      (run_exec && dec_bts && !flag_q) |=>
        instr_ready_q && !int_block_q && in_run;
  endproperty
  a_bts_nop: assert property (p_bts_nop) else $error("bts nop");

  property p_acc_clear;
    @(posedge core_clk) disable iff (sys_rst)
      (acc_clr && !flag_wr) |=> accum_high_q == 32'h0000_0000 &&
                                accum_low_q == 32'h0000_0000 &&
                                $stable(flag_q);
  endproperty
  a_acc_clear: assert property (p_acc_clear) else $error("acc clear");

  property p_bit_clear;
    @(posedge core_clk) disable iff (sys_rst)
      exec_ok |=> (!$past(dec_clampz) || !sat_q) &&
                  (!$past(dec_cmpz) || !flag_q);
  endproperty
  a_bit_clear: assert property (p_bit_clear) else $error("bit clear");

  property p_call_block;
    @(posedge core_clk) disable iff (sys_rst || ext_redirect)
      call_go |=> int_block_q ##1 int_block_q;
  endproperty
  a_call_block: assert property (p_call_block)
    else $error("call block");

endmodule : cbfc_exec

// >>> core/cbfc_pkg.sv
// package: constants and types for the conditional branch / flag clear unit
package cbfc_pkg;

  // ----------------------------------------------------------------
  // instruction encodings
  // ----------------------------------------------------------------
  localparam logic [7:0]  OP_BRANCH_ON_FLAG_SET   = 8'h89;  // upper byte
  localparam logic [7:0]  OP_DELAYED_BRANCH_SET   = 8'h8d;  // upper byte
  localparam logic [3:0]  OP_CALL_HI_NIBBLE       = 4'h0;   // bits 15:12
  localparam logic [7:0]  OP_CALL_LO_BYTE         = 8'h03;  // bits 7:0
  localparam logic [15:0] OP_ACCUMULATOR_ZERO     = 16'h0028;
  localparam logic [15:0] OP_CLAMP_BIT_ZERO       = 16'h0048;
  localparam logic [15:0] OP_COMPARE_BIT_ZERO     = 16'h0008;

  // ----------------------------------------------------------------
  // address arithmetic
  // ----------------------------------------------------------------
  localparam logic [31:0] PC_STEP                 = 32'h0000_0002;
  localparam logic [31:0] PC_BASE_OFFSET          = 32'h0000_0004;

  // ----------------------------------------------------------------
  // register map (byte offsets) and layout
  // ----------------------------------------------------------------
  localparam logic [4:0]  REG_STATUS              = 5'h00;
  localparam logic [4:0]  REG_MASK                = 5'h04;
  localparam logic [4:0]  REG_STATE               = 5'h08;
  localparam logic [4:0]  REG_PC                  = 5'h0c;
  localparam logic [4:0]  REG_RETURN_ADDR         = 5'h10;
  localparam int          EV_ILLEGAL_SLOT         = 0;
  localparam int          EV_BRANCH_TAKEN         = 1;
  localparam int          EV_CALL                 = 2;
  localparam int          EV_COUNT                = 3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] PC_RESET                = 32'h0000_0000;
  localparam logic [2:0]  MASK_RESET              = 3'h0;

  // ----------------------------------------------------------------
  // sequencing states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CBFC_RUN      = 3'b000,  // accepting any instruction
    CBFC_BR_WAIT2 = 3'b001,  // first refill cycle of a taken branch
    CBFC_BR_WAIT1 = 3'b010,  // second refill cycle of a taken branch
    CBFC_DL_WAIT  = 3'b011,  // extra cycle of a delayed branch
    CBFC_SLOT     = 3'b100   // waiting for the delay-slot instruction
  } cbfc_state_t;

endpackage : cbfc_pkg

// >>> verification/cbfc_exec_test.sv
// bench: self-checking test of the branch, call and clear unit
module cbfc_exec_test;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // signals and bench state
  // ----------------------------------------------------------------
  logic        core_clk;                      // 20 MHz core clock
  logic        sys_rst;                       // synchronous reset
  logic        instr_valid, ext_branch;       // issue strobe, far branch
  logic [15:0] instr;                         // instruction word
  logic [31:0] operand_reg, ext_target;       // call base, redirect addr
  logic        ext_redirect;                  // pc load strobe
  logic        flag_wr, flag_wr_val;          // outside flag write
  logic        sat_wr, sat_wr_val;            // outside clamp write
  logic        instr_ready_q, flag_q, sat_q;  // design outputs
  logic [31:0] pc_q, return_addr_q;           // design outputs
  logic [31:0] accum_high_q, accum_low_q;     // design outputs
  logic        int_block_q, illegal_slot_q;   // design outputs
  logic [4:0]  reg_addr;                      // register address
  logic [31:0] reg_wdata, reg_rdata_q;        // register data
  logic        reg_wr, reg_rd, irq_q;         // strobes and interrupt
  logic [31:0] seed = 32'h3a0604ff;           // xorshift state
  logic [31:0] pc;                            // modelled next address
  int          bad_count = 0;                 // mismatches seen
  int          checks = 0;                    // comparisons made
  typedef struct { int sel; logic [31:0] val; } cbfc_exp_t;
  cbfc_exp_t   exp_q[$];                      // expectations, oldest first
  localparam int S_PC = 0, S_RDY = 1, S_FLAG = 2, S_SAT = 3, S_AH = 4;
  localparam int S_AL = 5, S_INTB = 6, S_ILL = 7, S_RET = 8, S_RD = 9;
  localparam int S_IRQ = 10;

  cbfc_exec cbfc_exec_i (.core_clk(core_clk), .sys_rst(sys_rst),
    .instr_valid(instr_valid), .instr(instr), .operand_reg(operand_reg),
    .ext_branch(ext_branch), .ext_redirect(ext_redirect),
    .ext_target(ext_target), .flag_wr(flag_wr), .flag_wr_val(flag_wr_val),
    .sat_wr(sat_wr), .sat_wr_val(sat_wr_val),
    .instr_ready_q(instr_ready_q), .pc_q(pc_q),
    .return_addr_q(return_addr_q), .accum_high_q(accum_high_q),
    .accum_low_q(accum_low_q), .flag_q(flag_q), .sat_q(sat_q),
    .int_block_q(int_block_q), .illegal_slot_q(illegal_slot_q),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .irq_q(irq_q));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // clock: invert every half period of 25 ns
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // xorshift source for displacements, bases and data
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // doubled, sign-extended byte displacement
  function automatic logic [31:0] sx(input logic [7:0] d);
    return {{23{d[7]}}, d, 1'b0};
  endfunction

  // note one expected output value for the current cycle
  task automatic ex(input int s, input logic [31:0] v);
    exp_q.push_back('{s, v});
  endtask

  // set every strobe but ext_redirect once in this time step
  task automatic strobes(input logic v, rd, wr, fw, sw);
    instr_valid <= v;
    reg_rd      <= rd;
    reg_wr      <= wr;
    flag_wr     <= fw;
    sat_wr      <= sw;
  endtask

  // idle cycles: strobes low, call base scrambled
  task automatic step(input int n);
    strobes(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    ext_redirect <= 1'b0;
    operand_reg  <= rnd();
    repeat (n) @(posedge core_clk);
  endtask

  // present one instruction; taken at the next edge
  task automatic issue(input logic [15:0] w, input logic [31:0] r,
                       input logic xb);
    strobes(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    instr       <= w;
    operand_reg <= r;
    ext_branch  <= xb;
    @(posedge core_clk);
  endtask

  // register write or read; read data stand in the following cycle
  task automatic reg_op(input logic rd, input logic [4:0] a,
                        input logic [31:0] d);
    strobes(1'b0, rd, ~rd, 1'b0, 1'b0);
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
  endtask

  // outside write of flag or clamp bit
  task automatic bit_wr(input logic fw, input logic v);
    strobes(1'b0, 1'b0, 1'b0, fw, ~fw);
    flag_wr_val <= v;
    sat_wr_val  <= v;
    @(posedge core_clk);
  endtask

  // taken flag-set branch with refill stalls
  task automatic br_taken(input logic [7:0] d);
    issue({8'h89, d}, rnd(), 1'b0);
    pc = pc + 32'h4 + sx(d);
    ex(S_PC, pc);
    ex(S_RDY, 32'h0);
    step(1);
    ex(S_RDY, 32'h0);
    step(1);
    ex(S_RDY, 32'h1);
  endtask

  // delayed branch or call followed by its slot word
  task automatic dly(input logic [15:0] w, input logic [31:0] r,
                     input logic [31:0] tgt, input logic [15:0] slot,
                     input logic xb, input logic bad);
    issue(w, r, 1'b0);
    if (w[15:12] == 4'h0) ex(S_RET, pc + 32'h4);
    ex(S_PC, pc + 32'h2);
    ex(S_RDY, 32'h0);
    ex(S_INTB, 32'h1);
    step(1);
    ex(S_RDY, 32'h1);
    ex(S_INTB, 32'h1);
    issue(slot, rnd(), xb);
    pc = bad ? pc + 32'h2 : tgt;
    ex(S_PC, pc);
    ex(S_INTB, 32'h0);
    ex(S_ILL, {31'h0, bad});
    step(1);
    ex(S_ILL, 32'h0);
  endtask

  // mismatch report and counting
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    checks++;
    if (got !== want) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, got, want);
    end
  endtask

  // output chosen by an expectation
  function automatic logic [31:0] seen(input int s);
    case (s)
      S_PC:    return pc_q;
      S_RDY:   return {31'h0, instr_ready_q};
      S_FLAG:  return {31'h0, flag_q};
      S_SAT:   return {31'h0, sat_q};
      S_AH:    return accum_high_q;
      S_AL:    return accum_low_q;
      S_INTB:  return {31'h0, int_block_q};
      S_ILL:   return {31'h0, illegal_slot_q};
      S_RET:   return return_addr_q;
      S_RD:    return reg_rdata_q;
      default: return {31'h0, irq_q};
    endcase
  endfunction

  // monitor: settled outputs compared against the oldest notes
  always @(negedge core_clk) begin
    while (exp_q.size() > 0) begin
      check(seen(exp_q[0].sel), exp_q[0].val);
      void'(exp_q.pop_front());
    end
  end

  // verdict and end of run
  task automatic tally_and_finish();
    if (bad_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // watchdog: the sequence needs well under 400 cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    bad_count++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin : main
    logic [31:0] t;
    logic [31:0] r;
    {instr_valid, ext_branch, ext_redirect, flag_wr, flag_wr_val} = '0;
    {sat_wr, sat_wr_val, reg_wr, reg_rd} = '0;
    {instr, operand_reg, ext_target, reg_addr, reg_wdata} = '0;
    sys_rst = 1'b1;
    repeat (12) @(posedge core_clk);
    // values after reset, seen before the release edge
    ex(S_PC, 32'h0);
    ex(S_RDY, 32'h1);
    ex(S_IRQ, 32'h0);
    ex(S_INTB, 32'h0);
    sys_rst      <= 1'b0;
    t = rnd() & 32'hffff_fffe;
    ext_redirect <= 1'b1;
    ext_target   <= t;
    @(posedge core_clk);
    step(1);
    pc = t;
    ex(S_PC, pc);
    // flag low: flag-set branch falls through in one cycle
    issue(16'h8910, 32'h0, 1'b0);
    pc = pc + 32'h2;
    ex(S_PC, pc);
    ex(S_RDY, 32'h1);
    // flag high: range ends and two random displacements, irq masked
    bit_wr(1'b1, 1'b1);
    for (int k = 0; k < 4; k++) begin
      br_taken(k == 0 ? 8'h80 : k == 1 ? 8'h7f : 8'(rnd()));
    end
    ex(S_IRQ, 32'h0);
    reg_op(1'b0, cbfc_pkg::REG_MASK, rnd() | 32'h7);
    step(2);
    ex(S_IRQ, 32'h1);
    reg_op(1'b1, cbfc_pkg::REG_STATUS, rnd());
    ex(S_RD, 32'h2);
    step(2);
    ex(S_IRQ, 32'h0);
    reg_op(1'b1, 5'h1c, 32'h0);
    ex(S_RD, 32'h0);
    reg_op(1'b1, cbfc_pkg::REG_MASK, 32'h0);
    ex(S_RD, 32'h7);
    // delayed taken, slot clears the flag after the pair is fixed
    t = pc + 32'h4 + sx(8'hf0);
    dly(16'h8df0, 32'h0, t, cbfc_pkg::OP_COMPARE_BIT_ZERO, 1'b0, 1'b0);
    ex(S_FLAG, 32'h0);
    // flag low: delayed is a no-op, a branch behind it is legal
    issue(16'h8d40, 32'h0, 1'b0);
    pc = pc + 32'h2;
    ex(S_PC, pc);
    ex(S_INTB, 32'h0);
    issue(16'h8940, 32'h0, 1'b0);
    pc = pc + 32'h2;
    ex(S_PC, pc);
    ex(S_ILL, 32'h0);
    // call, base changes after issue, accumulator clear in slot
    r = rnd() & 32'hffff_fffe;
    t = pc + 32'h4 + r;
    dly(16'h0a03, r, t, cbfc_pkg::OP_ACCUMULATOR_ZERO, 1'b0, 1'b0);
    ex(S_AH, 32'h0);
    ex(S_AL, 32'h0);
    // flag-set branch in a taken delayed slot is refused
    bit_wr(1'b1, 1'b1);
    dly(16'h8d22, 32'h0, 32'h0, 16'h8902, 1'b0, 1'b1);
    // branch decoded elsewhere in a call slot is refused
    dly(16'h0503, rnd(), 32'h0, 16'h6033, 1'b1, 1'b1);
    reg_op(1'b1, cbfc_pkg::REG_STATUS, 32'h0);
    ex(S_RD, 32'h7);
    // clears: clamp bit, accumulator, then flag
    bit_wr(1'b0, 1'b1);
    issue(cbfc_pkg::OP_CLAMP_BIT_ZERO, 32'h0, 1'b0);
    pc = pc + 32'h2;
    ex(S_PC, pc);
    ex(S_SAT, 32'h0);
    ex(S_FLAG, 32'h1);
    issue(cbfc_pkg::OP_ACCUMULATOR_ZERO, 32'h0, 1'b0);
    pc = pc + 32'h2;
    ex(S_PC, pc);
    ex(S_FLAG, 32'h1);
    issue(cbfc_pkg::OP_COMPARE_BIT_ZERO, 32'h0, 1'b0);
    pc = pc + 32'h2;
    ex(S_PC, pc);
    ex(S_FLAG, 32'h0);
    // read back address and state words
    reg_op(1'b1, cbfc_pkg::REG_PC, 32'h0);
    ex(S_RD, pc);
    reg_op(1'b1, cbfc_pkg::REG_STATE, 32'h0);
    ex(S_RD, 32'h1);
    step(2);
    tally_and_finish();
  end

endmodule // cbfc_exec_test
